// *** include/bmrp_defines.vh ***
// Constants for the block memory read and protect command handler.
`ifndef BMRP_DEFINES_VH
`define BMRP_DEFINES_VH

// Memory function command codes.
`define BMRP_CMD_READ_MEM     8'hf0
`define BMRP_CMD_PROTECT      8'hc3
`define BMRP_CMD_READ_PROT    8'haa
`define BMRP_CMD_WRITE_BLOCK  8'h55

// Parameter byte layout and user memory geometry.
`define BMRP_BLK_MSB          4
`define BMRP_BLK_LSB          0
`define BMRP_LAST_BLOCK       5'h1e
`define BMRP_PAST_END         5'h1f
`define BMRP_NUM_BLOCKS       31
`define BMRP_BLOCK_BYTES      8
`define BMRP_MEM_BYTES        248
`define BMRP_LAST_OFFSET      4'h7
`define BMRP_CRC_LO_SLOT      4'h8
`define BMRP_CRC_HI_SLOT      4'h9

// Bytes sent back to the master.
`define BMRP_FILL_BYTE        8'hff
`define BMRP_ST_UNPROT        8'h0f
`define BMRP_ST_PROT          8'hf0
`define BMRP_CS_OK            8'haa
`define BMRP_CS_ALREADY       8'h55
`define BMRP_CS_FAIL          8'hee

// Reflected CRC-16 polynomial and cleared generator value.
`define BMRP_CRC_POLY         16'ha001
`define BMRP_CRC_CLEAR        16'h0000

// Release byte and programming time defaults.
`define BMRP_RELEASE_BYTE     8'haa
`define BMRP_PROG_CYCLES      16'd1000

// Transmit buffer shape.
`define BMRP_FIFO_WIDTH       8
`define BMRP_FIFO_DEPTH       16
`define BMRP_FIFO_AW          4

`endif

// *** src/bmrp_core.v ***
// Memory function command handler: read, protect and protection readout with a transmit FIFO.
`timescale 1ns/1ps
`include "bmrp_defines.vh"

module bmrp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset.
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire             flush,
    // Filling side.
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output wire             in_ready,
    // Draining side, both outputs registered.
    output reg              out_valid_q,
    output reg  [WIDTH-1:0] out_data_q,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    wire            push;
    wire            pop;

    // The output register counts as one more slot, so real depth is DEPTH plus one.
    assign in_ready = (count_q != DEPTH[AW:0]);
    assign push     = in_valid && in_ready;
    assign pop      = (count_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);

    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q    <= {AW{1'b0}};
            rd_ptr_q    <= {AW{1'b0}};
            count_q     <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
            out_data_q  <= {WIDTH{1'b0}};
        end else if (flush) begin
            wr_ptr_q    <= {AW{1'b0}};
            rd_ptr_q    <= {AW{1'b0}};
            count_q     <= {(AW+1){1'b0}};
            out_valid_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q    <= rd_ptr_q + 1'b1;
                out_data_q  <= mem[rd_ptr_q];
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // bmrp_fifo

module bmrp_core #(
    parameter [7:0]  RELEASE_BYTE = `BMRP_RELEASE_BYTE,
    parameter [15:0] PROG_CYCLES  = `BMRP_PROG_CYCLES
) (
    // Clock and reset.
    input  wire        ref_clk,
    input  wire        rst_n,
    // Byte link layer: bus reset and received bytes.
    input  wire        bus_rst,
    input  wire        rx_valid,
    input  wire [7:0]  rx_byte,
    // Bytes to send, drained by the link layer.
    output wire        tx_valid,
    output wire [7:0]  tx_byte,
    input  wire        tx_ready,
    // Write engine hand-off.
    output reg         write_start_q,
    output reg  [4:0]  write_block_q,
    input  wire        mem_wr_en,
    input  wire [7:0]  mem_wr_addr,
    input  wire [7:0]  mem_wr_data,
    // Nonvolatile programming result and busy flag.
    input  wire        prog_fail,
    output reg         busy_q
);
    localparam [9:0] S_IDLE  = 10'h001;
    localparam [9:0] S_PARAM = 10'h002;
    localparam [9:0] S_CRCLO = 10'h004;
    localparam [9:0] S_CRCHI = 10'h008;
    localparam [9:0] S_READ  = 10'h010;
    localparam [9:0] S_REL   = 10'h020;
    localparam [9:0] S_PROG  = 10'h040;
    localparam [9:0] S_STAT  = 10'h080;
    localparam [9:0] S_PSTAT = 10'h100;
    localparam [9:0] S_HALT  = 10'h200;

    reg [7:0]                   user_mem [0:`BMRP_MEM_BYTES-1];
    reg [`BMRP_NUM_BLOCKS-1:0]  prot_q;
    reg [9:0]                   state_q;
    reg [7:0]                   cmd_q;
    reg [4:0]                   blk_q;
    reg [3:0]                   off_q;
    reg [15:0]                  crc_q;
    reg [15:0]                  cnt_q;
    reg [7:0]                   status_q;
    reg                         push_valid;
    reg [7:0]                   push_data;
    wire                        push_ready;
    wire [4:0]                  rx_blk;
    wire [4:0]                  wr_blk;
    wire [7:0]                  rd_byte;

    // Shift one byte into the reflected CRC-16, least-significant bit first.
    function [15:0] crc16_byte;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                r = (r[0] ^ d[i]) ? ((r >> 1) ^ `BMRP_CRC_POLY) : (r >> 1);
            end
            crc16_byte = r;
        end
    endfunction

    // Protection status of a block, with the fill byte beyond the last block.
    function [7:0] prot_byte;
        input [4:0]                  b;
        input [`BMRP_NUM_BLOCKS-1:0] p;
        begin
            prot_byte = (b > `BMRP_LAST_BLOCK) ? `BMRP_FILL_BYTE :
                        (p[b] ? `BMRP_ST_PROT : `BMRP_ST_UNPROT);
        end
    endfunction

    assign rx_blk  = rx_byte[`BMRP_BLK_MSB:`BMRP_BLK_LSB];
    assign wr_blk  = mem_wr_addr[7:3];
    assign rd_byte = user_mem[{blk_q, off_q[2:0]}];

    // The write engine may not touch a protected block or any address past the end.
    always @(posedge ref_clk) begin
        if (mem_wr_en && (wr_blk <= `BMRP_LAST_BLOCK) && !prot_q[wr_blk]) begin
            user_mem[mem_wr_addr] <= mem_wr_data;
        end
    end

    // Byte offered to the transmit FIFO in each state.
    always @* begin
        push_valid = 1'b0;
        push_data  = `BMRP_FILL_BYTE;
        case (state_q)
            S_CRCLO: begin
                push_valid = 1'b1;
                push_data  = ~crc_q[7:0];
            end
            S_CRCHI: begin
                push_valid = 1'b1;
                push_data  = ~crc_q[15:8];
            end
            S_READ: begin
                push_valid = 1'b1;
                if (blk_q > `BMRP_LAST_BLOCK) begin
                    push_data = `BMRP_FILL_BYTE;
                end else if (off_q == `BMRP_CRC_LO_SLOT) begin
                    push_data = ~crc_q[7:0];
                end else if (off_q == `BMRP_CRC_HI_SLOT) begin
                    push_data = ~crc_q[15:8];
                end else begin
                    push_data = rd_byte;
                end
            end
            S_STAT: begin
                push_valid = 1'b1;
                push_data  = status_q;
            end
            S_PSTAT: begin
                push_valid = 1'b1;
                push_data  = prot_byte(blk_q, prot_q);
            end
            default: push_valid = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= S_IDLE;
            cmd_q         <= 8'h00;
            blk_q         <= 5'h00;
            off_q         <= 4'h0;
            crc_q         <= `BMRP_CRC_CLEAR;
            cnt_q         <= 16'h0000;
            status_q      <= 8'h00;
            prot_q        <= {`BMRP_NUM_BLOCKS{1'b0}};
            write_start_q <= 1'b0;
            write_block_q <= 5'h00;
            busy_q        <= 1'b0;
        end else begin
            write_start_q <= 1'b0;
            busy_q        <= !(state_q == S_IDLE || state_q == S_HALT);
            if (bus_rst) begin
                state_q <= S_IDLE;
                busy_q  <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (rx_valid) begin
                            cmd_q <= rx_byte;
                            crc_q <= crc16_byte(`BMRP_CRC_CLEAR, rx_byte);
                            if (rx_byte == `BMRP_CMD_READ_MEM ||
                                rx_byte == `BMRP_CMD_PROTECT ||
                                rx_byte == `BMRP_CMD_READ_PROT ||
                                rx_byte == `BMRP_CMD_WRITE_BLOCK) begin
                                state_q <= S_PARAM;
                            end else begin
                                state_q <= S_HALT;
                            end
                        end
                    end
                    S_PARAM: begin
                        if (rx_valid) begin
                            blk_q <= rx_blk;
                            crc_q <= crc16_byte(crc_q, rx_byte);
                            if (rx_blk > `BMRP_LAST_BLOCK) begin
                                state_q <= S_HALT;
                            end else begin
                                state_q <= S_CRCLO;
                            end
                        end
                    end
                    S_CRCLO: begin
                        if (push_ready) begin
                            state_q <= S_CRCHI;
                        end
                    end
                    S_CRCHI: begin
                        if (push_ready) begin
                            crc_q <= `BMRP_CRC_CLEAR;
                            off_q <= 4'h0;
                            case (cmd_q)
                                `BMRP_CMD_READ_MEM: begin
                                    state_q <= S_READ;
                                end
                                `BMRP_CMD_PROTECT: begin
                                    state_q <= S_REL;
                                end
                                `BMRP_CMD_READ_PROT: begin
                                    state_q <= S_PSTAT;
                                end
                                default: begin
                                    // The write engine owns the rest of the write flow.
                                    write_start_q <= 1'b1;
                                    write_block_q <= blk_q;
                                    state_q       <= S_HALT;
                                end
                            endcase
                        end
                    end
                    S_READ: begin
                        if (push_ready && blk_q <= `BMRP_LAST_BLOCK) begin
                            if (off_q <= `BMRP_LAST_OFFSET) begin
                                crc_q <= crc16_byte(crc_q, rd_byte);
                                off_q <= off_q + 4'h1;
                            end else if (off_q == `BMRP_CRC_LO_SLOT) begin
                                off_q <= `BMRP_CRC_HI_SLOT;
                            end else begin
                                crc_q <= `BMRP_CRC_CLEAR;
                                off_q <= 4'h0;
                                blk_q <= blk_q + 5'h01;
                            end
                        end
                    end
                    S_REL: begin
                        if (rx_valid) begin
                            cnt_q <= 16'h0000;
                            if (rx_byte == RELEASE_BYTE) begin
                                state_q <= S_PROG;
                            end else begin
                                state_q <= S_HALT;
                            end
                        end
                    end
                    S_PROG: begin
                        if (prot_q[blk_q]) begin
                            status_q <= `BMRP_CS_ALREADY;
                            state_q  <= S_STAT;
                        end else if (cnt_q == PROG_CYCLES - 16'h0001) begin
                            state_q <= S_STAT;
                            if (prog_fail) begin
                                status_q <= `BMRP_CS_FAIL;
                            end else begin
                                status_q       <= `BMRP_CS_OK;
                                prot_q[blk_q]  <= 1'b1;
                            end
                        end else begin
                            cnt_q <= cnt_q + 16'h0001;
                        end
                    end
                    S_STAT: begin
                        if (push_ready) begin
                            state_q <= S_HALT;
                        end
                    end
                    S_PSTAT: begin
                        if (push_ready && blk_q != `BMRP_PAST_END) begin
                            blk_q <= blk_q + 5'h01;
                        end
                    end
                    S_HALT: state_q <= S_HALT;
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // Bytes already queued must not leak into the next flow, so a bus reset flushes them.
    bmrp_fifo #(
        .WIDTH (`BMRP_FIFO_WIDTH),
        .DEPTH (`BMRP_FIFO_DEPTH),
        .AW    (`BMRP_FIFO_AW)
    ) u_tx_fifo (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .flush       (bus_rst),
        .in_valid    (push_valid),
        .in_data     (push_data),
        .in_ready    (push_ready),
        .out_valid_q (tx_valid),
        .out_data_q  (tx_byte),
        .out_ready   (tx_ready)
    );
endmodule // bmrp_core

// *** tb/bmrp_core_props.sv ***
// Concurrent checks on the ports of the memory command handler.
`timescale 1ns/1ps
module bmrp_core_props (
    // Clock and reset.
    input wire       ref_clk,
    input wire       rst_n,
    // Link side.
    input wire       bus_rst,
    input wire       tx_valid,
    input wire [7:0] tx_byte,
    input wire       tx_ready,
    // Write hand-off and status.
    input wire       write_start_q,
    input wire [4:0] write_block_q,
    input wire       busy_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_reset_quiet: assert property (
        $rose(rst_n) |-> !tx_valid && !write_start_q && !busy_q)
        else $error("outputs active right after reset");
    chk_bus_flush: assert property (bus_rst |=> !tx_valid)
        else $error("reply still offered after bus reset");
    chk_quiet_after: assert property (bus_rst |=> !tx_valid [*4])
        else $error("reply sooner than command and parameter allow");
    chk_tx_hold: assert property (
        tx_valid && !tx_ready && !bus_rst |=> tx_valid && $stable(tx_byte))
        else $error("offered byte changed before it was taken");
    chk_start_pulse: assert property (write_start_q |=> !write_start_q)
        else $error("write start longer than one cycle");
    chk_block_range: assert property (write_start_q |-> write_block_q <= 5'h1e)
        else $error("write start with block past end");
    chk_block_stable: assert property (write_start_q |=> $stable(write_block_q))
        else $error("start block moved after hand-off");
    chk_start_late: assert property (bus_rst |=> !write_start_q [*4])
        else $error("write start before confirmation");

    cover property (tx_valid && tx_ready);
    cover property (bus_rst && tx_valid);
    cover property (write_start_q);
    cover property ((tx_valid && !tx_ready) [*8]);
endmodule // bmrp_core_props

bind bmrp_core bmrp_core_props u_props (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .bus_rst       (bus_rst),
    .tx_valid      (tx_valid),
    .tx_byte       (tx_byte),
    .tx_ready      (tx_ready),
    .write_start_q (write_start_q),
    .write_block_q (write_block_q),
    .busy_q        (busy_q)
);

// *** tb/bmrp_master.sv ***
// Bus master model: sends bytes, drains replies, issues bus resets.
`timescale 1ns/1ps
module bmrp_master (
    // Clock.
    input  wire       ref_clk,
    // Towards the device.
    output reg        bus_rst,
    output reg        rx_valid,
    output reg  [7:0] rx_byte,
    // Replies.
    input  wire       tx_valid,
    input  wire [7:0] tx_byte,
    output reg        tx_ready
);
    integer n;
    initial begin
        bus_rst = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // Every flow starts from a bus reset; it also ends any flow.
    task reset_bus;
        begin
            @(negedge ref_clk);
            bus_rst = 1'b1;
            @(negedge ref_clk);
            bus_rst = 1'b0;
        end
    endtask
    // A released data line shows the inverse, so a stale byte cannot pass.
    task send(input [7:0] d);
        begin
            @(negedge ref_clk);
            rx_valid = 1'b1;
            rx_byte = d;
            @(negedge ref_clk);
            rx_valid = 1'b0;
            rx_byte = ~d;
        end
    endtask
    // A slow master idles before asking, which lets the device's buffer fill.
    task take(input integer stall, output [7:0] d);
        begin
            repeat (stall) @(negedge ref_clk);
            @(negedge ref_clk);
            tx_ready = 1'b1;
            n = 0;
            while (tx_valid !== 1'b1 && n < 300) begin
                n = n + 1;
                @(negedge ref_clk);
            end
            d = (n < 300) ? tx_byte : 8'hxx;
            @(negedge ref_clk);
            tx_ready = 1'b0;
        end
    endtask
endmodule // bmrp_master

// *** tb/testbench.sv ***
// Self-checking bench for the memory function command handler.
`timescale 1ns/1ps
`include "bmrp_defines.vh"
module testbench;
    reg         ref_clk;
    reg         rst_n;
    reg         mem_wr_en;
    reg  [7:0]  mem_wr_addr;
    reg  [7:0]  mem_wr_data;
    reg         prog_fail;
    wire        bus_rst;
    wire        rx_valid;
    wire [7:0]  rx_byte;
    wire        tx_valid;
    wire [7:0]  tx_byte;
    wire        tx_ready;
    wire        write_start_q;
    wire [4:0]  write_block_q;
    wire        busy_q;
    integer     n_starts = 0;
    integer     n_errors;
    integer     total_checks;
    integer     i;
    integer     k;
    reg  [15:0] c;
    reg  [7:0]  b;

    bmrp_core #(.PROG_CYCLES(16'd4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_rst(bus_rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .write_start_q(write_start_q), .write_block_q(write_block_q),
        .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .prog_fail(prog_fail), .busy_q(busy_q));
    bmrp_master u_master (.ref_clk(ref_clk), .bus_rst(bus_rst),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // The start pulse comes while the confirmation is still being drained, so count it here.
    always @(negedge ref_clk) begin
        if (write_start_q === 1'b1) begin
            n_starts <= n_starts + 1;
        end
    end

    function [15:0] crc_upd(input [15:0] cv, input [7:0] d);
        integer j;
        begin
            crc_upd = cv;
            for (j = 0; j < 8; j = j + 1) begin
                if (crc_upd[0] ^ d[j])
                    crc_upd = (crc_upd >> 1) ^ `BMRP_CRC_POLY;
                else
                    crc_upd = crc_upd >> 1;
            end
        end
    endfunction

    task check(input [7:0] got, input [7:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task take_check(input integer stall, input [7:0] exp);
        begin
            u_master.take(stall, b);
            check(b, exp);
        end
    endtask

    // Sends command and parameter, then expects the inverted confirmation.
    task cmd_crc(input [7:0] cm, input [7:0] p);
        begin
            u_master.reset_bus;
            u_master.send(cm);
            u_master.send(p);
            c = crc_upd(crc_upd(16'h0000, cm), p);
            take_check(0, ~c[7:0]);
            take_check(0, ~c[15:8]);
        end
    endtask

    task quiet(input integer cyc);
        begin
            k = 0;
            repeat (cyc) @(negedge ref_clk) k = k + (tx_valid === 1'b1);
            check(k[7:0], 8'h00);
        end
    endtask

    task t_read;
        begin
            cmd_crc(`BMRP_CMD_READ_MEM, 8'hfd);
            for (i = 232; i < 248; i = i + 1) begin
                if (i % 8 == 0)
                    c = 16'h0000;
                // A long stall fills the buffer and must lose nothing.
                take_check((i == 235) ? 30 : 0, i[7:0] ^ 8'h3c);
                c = crc_upd(c, i[7:0] ^ 8'h3c);
                if (i % 8 == 7) begin
                    take_check(0, ~c[7:0]);
                    take_check(0, ~c[15:8]);
                end
            end
            for (i = 0; i < 3; i = i + 1)
                take_check(0, `BMRP_FILL_BYTE);
            $display("read done");
        end
    endtask

    task t_abort;
        begin
            cmd_crc(`BMRP_CMD_READ_MEM, 8'h00);
            take_check(0, 8'h3c);
            u_master.reset_bus;
            check({7'h00, tx_valid}, 8'h00);
            quiet(20);
            u_master.send(8'h99);
            u_master.send(8'h00);
            quiet(20);
            u_master.reset_bus;
            u_master.send(`BMRP_CMD_READ_MEM);
            u_master.send(8'h1f);
            quiet(30);
            $display("abort and refusal done");
        end
    endtask

    task t_prot(input [7:0] p, input fail, input [7:0] exp);
        begin
            prog_fail = fail;
            cmd_crc(`BMRP_CMD_PROTECT, p);
            quiet(10);
            check({7'h00, busy_q}, 8'h01);
            u_master.send(`BMRP_RELEASE_BYTE);
            take_check(0, exp);
            quiet(10);
            check({7'h00, busy_q}, 8'h00);
            prog_fail = 1'b0;
        end
    endtask

    task t_status;
        begin
            cmd_crc(`BMRP_CMD_READ_PROT, 8'hc2);
            for (i = 2; i < 31; i = i + 1)
                take_check(0, (i == 3) ? `BMRP_ST_PROT : `BMRP_ST_UNPROT);
            for (i = 0; i < 2; i = i + 1)
                take_check(0, `BMRP_FILL_BYTE);
            u_master.reset_bus;
            check({7'h00, tx_valid}, 8'h00);
            $display("status readout done");
        end
    endtask

    task t_write;
        begin
            k = n_starts;
            cmd_crc(`BMRP_CMD_WRITE_BLOCK, 8'he7);
            repeat (4) @(negedge ref_clk);
            k = n_starts - k;
            check(k[7:0], 8'h01);
            check({3'h0, write_block_q}, 8'h07);
            $display("write hand-off done");
        end
    endtask

    task results;
        begin
            $display("checks=%0d mismatches=%0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors = n_errors + 1;
        results;
    end

    initial begin
        n_errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        mem_wr_en = 1'b0;
        mem_wr_addr = 8'h00;
        mem_wr_data = 8'h00;
        prog_fail = 1'b0;
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        // The array has no reset, so every byte is loaded before reading.
        for (i = 0; i < 248; i = i + 1) begin
            @(negedge ref_clk);
            mem_wr_en = 1'b1;
            mem_wr_addr = i[7:0];
            mem_wr_data = i[7:0] ^ 8'h3c;
        end
        @(negedge ref_clk);
        mem_wr_en = 1'b0;
        t_read;
        t_abort;
        t_prot(8'h43, 1'b0, `BMRP_CS_OK);
        t_prot(8'h03, 1'b0, `BMRP_CS_ALREADY);
        t_status;
        t_prot(8'h1e, 1'b1, `BMRP_CS_FAIL);
        $display("protect done");
        t_write;
        results;
    end
endmodule // testbench
